// ---- test/adc_result_monitor_tb.sv ----
`timescale 1ns/1ps
module adc_result_monitor_tb;
	import adcmon_pkg::*;
	logic         ref_clk = 1'b0, resetn = 1'b0, fm = 1'b0, sm = 1'b0, start = 1'b0, live = 1'b0;
	logic         fixed_repeat_mode = 1'b0, scan_repeat_mode = 1'b0;
	logic         monitor_irq_0, monitor_irq_1, irq;
	adcmon_bus_s  bus = '0;
	adcmon_conv_s conv;
	logic [31:0]  reg_rdata, e_rd, seed = 32'h0000398B;
	logic [11:0]  cv0 = 12'h000, cv1 = 12'h000, compare_value_0 = 12'h000, compare_value_1 = 12'h000, s_res = 12'h000;
	logic [3:0]   s_ch = 4'h0;
	logic [1:0]   st, mk, e_mon;
	int           miscompares = 0, cmp_count = 0;
	int           cnt[2], code[2], sel[2], en[2], meth[2], dir[2];

	adcmon_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .reg_rdata(reg_rdata), .conv(conv),
		.fixed_repeat_mode(fixed_repeat_mode), .scan_repeat_mode(scan_repeat_mode),
		.compare_value_0(compare_value_0), .compare_value_1(compare_value_1),
		.monitor_irq_0(monitor_irq_0), .monitor_irq_1(monitor_irq_1), .irq(irq));
	adcmon_conv_model i_conv (.ref_clk(ref_clk), .resetn(resetn), .start(start), .chan(s_ch), .value(s_res), .conv(conv));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] rd_val(input logic [7:0] a);
		int m;
		m = a[2];
		if (a == ADCMON_OFS_CTRL0 || a == ADCMON_OFS_CTRL1)
			return {20'h0, 4'(code[m]), 1'(en[m]), 1'b0, 1'(meth[m]), 1'(dir[m]), 4'(sel[m])};
		if (a == ADCMON_OFS_STATUS)
			return {30'h0, st};
		if (a == ADCMON_OFS_MASK)
			return {30'h0, mk};
		return 32'h0;
	endfunction

	// Reference model, sees the same inputs the design samples
	always @(posedge ref_clk) begin
		int m;
		logic [11:0] c;
		logic ok;
		logic [1:0] fire;
		if (!resetn) begin
			live = 1'b1;
			{st, mk, e_mon, e_rd} = '0;
			for (m = 0; m < 2; m++) begin
				cnt[m] = 0;
				code[m] = 0;
				sel[m] = 0;
				en[m] = 0;
				meth[m] = 0;
				dir[m] = 0;
			end
		end else begin
			fire = 2'h0;
			e_rd = bus.re ? rd_val(bus.addr) : 32'h0;
			for (m = 0; m < 2; m++) begin
				c = m ? compare_value_1 : compare_value_0;
				ok = dir[m] ? conv.result < c : conv.result > c;
				if (conv.done && (fixed_repeat_mode || scan_repeat_mode) && en[m] != 0 && sel[m] < ADCMON_CHAN_NUM
						&& conv.channel == sel[m]) begin
					if (meth[m] == 0) begin
						cnt[m] = ok ? (cnt[m] < 16 ? cnt[m] + 1 : 16) : 0;
						fire[m] = ok && cnt[m] >= code[m] + 1;
					end else if (ok) begin
						cnt[m]++;
						fire[m] = cnt[m] >= code[m] + 1;
						if (fire[m]) cnt[m] = 0;
					end
				end
				if (bus.we && bus.addr == 8'(4 * m)) begin
					code[m] = bus.wdata[11:8];
					en[m] = bus.wdata[7];
					meth[m] = bus.wdata[5];
					dir[m] = bus.wdata[4];
					sel[m] = bus.wdata[3:0];
				end
				if (en[m] == 0) cnt[m] = 0;
			end
			if (bus.we && bus.addr == ADCMON_OFS_STATUS) st = st & ~bus.wdata[1:0];
			st = st | fire;
			if (bus.we && bus.addr == ADCMON_OFS_MASK) mk = bus.wdata[1:0];
			e_mon = fire;
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	always @(negedge ref_clk) begin
		if (live) begin
			chk("monitor_irq_0", e_mon[0], monitor_irq_0);
			chk("monitor_irq_1", e_mon[1], monitor_irq_1);
			chk("irq", |(st & mk), irq);
			chk("reg_rdata", e_rd, reg_rdata);
		end
	end

	task automatic cyc(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r, input logic go,
			input logic [3:0] ch, input logic [11:0] res);
		bus <= '{a, d, w, r};
		start <= go;
		s_ch <= ch;
		s_res <= res;
		fixed_repeat_mode <= fm;
		scan_repeat_mode <= sm;
		compare_value_0 <= cv0;
		compare_value_1 <= cv1;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cyc(a, d, 1'b1, 1'b0, 1'b0, 4'h0, 12'h000);
	endtask
	task automatic rd(input logic [7:0] a);
		cyc(a, 32'h0, 1'b0, 1'b1, 1'b0, 4'h0, 12'h000);
	endtask
	task automatic cv(input logic [3:0] ch, input logic [11:0] res);
		cyc(8'h00, 32'h0, 1'b0, 1'b0, 1'b1, ch, res);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		miscompares++;
		end_of_test();
	end

	initial begin
		int i;
		logic [31:0] r;
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		for (i = 0; i < 20; i += 4) rd(8'(i));
		wr(ADCMON_OFS_CTRL0, 32'hFFFFFFFF);
		rd(ADCMON_OFS_CTRL0);
		wr(ADCMON_OFS_MASK, 32'h00000003);
		{cv0, cv1, fm} = {12'h800, 12'h100, 1'b1};
		// Serial, sixteen matches, saturation, then equal and a fresh match
		wr(ADCMON_OFS_CTRL0, 32'h00000F85);
		for (i = 0; i < 20; i++) cv(4'h5, 12'h801);
		cv(4'h5, 12'h800);
		cv(4'h5, 12'h900);
		// Cumulative, three matches, misses in between on monitor 1
		wr(ADCMON_OFS_CTRL1, 32'h000002B3);
		for (i = 0; i < 9; i++) cv(4'h3, i[0] ? 12'h0FF : 12'h100);
		for (i = 12; i < 16; i++) begin
			wr(ADCMON_OFS_CTRL0, 32'h00000080 | i);
			cv(4'(i), 12'hFFF);
		end
		fm = 1'b0;
		wr(ADCMON_OFS_CTRL0, 32'h00000085);
		cv(4'h5, 12'hFFF);
		sm = 1'b1;
		wr(ADCMON_OFS_CTRL0, 32'h00000185);
		cv(4'h5, 12'hFFF);
		wr(ADCMON_OFS_CTRL0, 32'h00000105);
		wr(ADCMON_OFS_CTRL0, 32'h00000185);
		cv(4'h5, 12'hFFF);
		rd(ADCMON_OFS_STATUS);
		wr(ADCMON_OFS_STATUS, 32'h00000003);
		rd(ADCMON_OFS_STATUS);
		// Random mix of register traffic and conversions
		for (i = 0; i < 4000; i++) begin
			r = xs();
			if (i % 256 == 0) {fm, sm, cv0, cv1} = {r[31:30], r[27:16], r[15:4]};
			case (r[1:0])
				2'd0: cyc(8'(4 * r[2]), {20'h0, r[3] ? r[11:8] : {2'b00, r[11:10]}, r[7] | r[6], r[6:0]}, 1'b1, 1'b0,
					r[12] | r[13], r[14] ? 4'(sel[r[15]]) : r[19:16], (r[15] ? cv1 : cv0) + r[22:20] - 12'h003);
				2'd1: cyc({3'h0, r[4:2], 2'b00}, 32'h0, 1'b0, 1'b1,
					r[12] | r[13], r[14] ? 4'(sel[r[15]]) : r[19:16], (r[15] ? cv1 : cv0) + r[22:20] - 12'h003);
				2'd2: cyc(r[2] ? ADCMON_OFS_MASK : ADCMON_OFS_STATUS, {30'h0, r[25:24]}, 1'b1, 1'b0,
					r[12] | r[13], r[14] ? 4'(sel[r[15]]) : r[19:16], (r[15] ? cv1 : cv0) + r[22:20] - 12'h003);
				default: cyc(8'h00, 32'h0, 1'b0, 1'b0,
					r[12] | r[13], r[14] ? 4'(sel[r[15]]) : r[19:16], (r[15] ? cv1 : cv0) + r[22:20] - 12'h003);
			endcase
		end
		repeat (4) cyc(8'h00, 32'h0, 1'b0, 1'b0, 1'b0, 4'h0, 12'h000);
		end_of_test();
	end
endmodule

// ---- test/adcmon_conv_model.sv ----
`timescale 1ns/1ps
module adcmon_conv_model
	import adcmon_pkg::*;
(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    resetn,
	// Requests from the bench
	input  wire logic                    start,
	input  wire logic [3:0]              chan,
	input  wire logic [ADCMON_RES_W-1:0] value,
	// Result path
	output adcmon_conv_s                 conv = '0
);
	// Channel and result turn over between completions so stale data never looks valid
	always @(posedge ref_clk) begin
		if (!resetn) begin
			conv <= '0;
		end else if (start) begin
			conv <= '{1'b1, chan, value};
		end else begin
			conv <= '{1'b0, ~conv.channel, ~conv.result};
		end
	end
endmodule

// ---- verilog/adcmon_pkg.sv ----
package adcmon_pkg;

	// Register byte offsets
	localparam logic [7:0] ADCMON_OFS_CTRL0  = 8'h00;
	localparam logic [7:0] ADCMON_OFS_CTRL1  = 8'h04;
	localparam logic [7:0] ADCMON_OFS_STATUS = 8'h08;
	localparam logic [7:0] ADCMON_OFS_MASK   = 8'h0C;

	// Control register field positions
	localparam int ADCMON_POS_CHAN   = 0;
	localparam int ADCMON_POS_DIR    = 4;
	localparam int ADCMON_POS_METHOD = 5;
	localparam int ADCMON_POS_EN     = 7;
	localparam int ADCMON_POS_COUNT  = 8;

	// Sizes
	localparam int ADCMON_NUM_MON  = 2;
	localparam int ADCMON_RES_W    = 12;
	localparam int ADCMON_CHAN_NUM = 12;
	localparam int ADCMON_CNT_W    = 5;

	// Counting method and direction codes
	localparam logic ADCMON_METHOD_SERIAL = 1'b0;
	localparam logic ADCMON_METHOD_CUMUL  = 1'b1;
	localparam logic ADCMON_DIR_BIGGER    = 1'b0;
	localparam logic ADCMON_DIR_SMALLER   = 1'b1;

	// Counter limits
	localparam logic [ADCMON_CNT_W-1:0] ADCMON_CNT_MAX = 5'h10;

	typedef struct packed {
		logic [3:0] judge_count;
		logic       enable;
		logic       method;
		logic       direction;
		logic [3:0] channel_sel;
	} adcmon_ctrl_s;

	localparam adcmon_ctrl_s ADCMON_CTRL_RST = '{4'h0, 1'b0, 1'b0, 1'b0, 4'h0};

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} adcmon_bus_s;

	typedef struct packed {
		logic                    done;
		logic [3:0]              channel;
		logic [ADCMON_RES_W-1:0] result;
	} adcmon_conv_s;

	typedef struct packed {
		adcmon_ctrl_s [ADCMON_NUM_MON-1:0]                  ctrl;
		logic [ADCMON_NUM_MON-1:0][ADCMON_CNT_W-1:0]        cnt;
		logic [ADCMON_NUM_MON-1:0]                          status;
		logic [ADCMON_NUM_MON-1:0]                          mask;
		logic [ADCMON_NUM_MON-1:0]                          pulse;
		logic [31:0]                                        rdata;
	} adcmon_state_s;

endpackage

// ---- verilog/adcmon_top.sv ----
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module adcmon_top
	import adcmon_pkg::*;
#(
	parameter int NUM_CH = ADCMON_CHAN_NUM
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    resetn,
	// Register port
	input  wire adcmon_bus_s             bus,
	output logic [31:0]                  reg_rdata,
	// Converter result path and sequencer mode
	input  wire adcmon_conv_s            conv,
	input  wire logic                    fixed_repeat_mode,
	input  wire logic                    scan_repeat_mode,
	input  wire logic [ADCMON_RES_W-1:0] compare_value_0,
	input  wire logic [ADCMON_RES_W-1:0] compare_value_1,
	// Interrupts
	output logic                         monitor_irq_0,
	output logic                         monitor_irq_1,
	output logic                         irq
);

	if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_num_ch
		$error("NUM_CH must lie between 1 and 16");
	end

	function automatic logic [31:0] ctrl_pack(input adcmon_ctrl_s c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[ADCMON_POS_COUNT +: 4] = c.judge_count;
		w[ADCMON_POS_EN]         = c.enable;
		w[ADCMON_POS_METHOD]     = c.method;
		w[ADCMON_POS_DIR]        = c.direction;
		w[ADCMON_POS_CHAN +: 4]  = c.channel_sel;
		return w;
	endfunction

	function automatic adcmon_ctrl_s ctrl_unpack(input logic [31:0] w);
		adcmon_ctrl_s c;
		c.judge_count = w[ADCMON_POS_COUNT +: 4];
		c.enable      = w[ADCMON_POS_EN];
		c.method      = w[ADCMON_POS_METHOD];
		c.direction   = w[ADCMON_POS_DIR];
		c.channel_sel = w[ADCMON_POS_CHAN +: 4];
		return c;
	endfunction

	// Required number of matches
	function automatic logic [ADCMON_CNT_W-1:0] target(input logic [3:0] code);
		return {1'b0, code} + 5'h01;
	endfunction

	function automatic logic result_match(input logic dir, input logic [ADCMON_RES_W-1:0] res,
					      input logic [ADCMON_RES_W-1:0] cmp);
		return (dir == ADCMON_DIR_SMALLER) ? (res < cmp) : (res > cmp);
	endfunction

	adcmon_state_s                           s_q;
	adcmon_state_s                           s_d;
	logic [ADCMON_NUM_MON-1:0]               fire;
	logic [ADCMON_NUM_MON-1:0]               match;
	logic [ADCMON_NUM_MON-1:0][ADCMON_RES_W-1:0] cmp_val;
	logic                                    repeat_mode;

	assign cmp_val[0]  = compare_value_0;
	assign cmp_val[1]  = compare_value_1;
	assign repeat_mode = fixed_repeat_mode | scan_repeat_mode;

	// Per-monitor conversion event and compare outcome
	always_comb begin
		for (int m = 0; m < ADCMON_NUM_MON; m++) begin
			fire[m]  = conv.done && repeat_mode && s_q.ctrl[m].enable &&
				   ({1'b0, s_q.ctrl[m].channel_sel} < 5'(NUM_CH)) &&
				   (conv.channel == s_q.ctrl[m].channel_sel);
			match[m] = result_match(s_q.ctrl[m].direction, conv.result, cmp_val[m]);
		end
	end

	always_comb begin
		logic [ADCMON_CNT_W-1:0] nxt;
		nxt       = '0;
		s_d       = s_q;
		s_d.pulse = '0;
		s_d.rdata = 32'h0000_0000;
		for (int m = 0; m < ADCMON_NUM_MON; m++) begin
			nxt = s_q.cnt[m];
			if (!s_q.ctrl[m].enable) begin
				s_d.cnt[m] = '0;
			end else if (fire[m] && match[m]) begin
				nxt = (s_q.cnt[m] < ADCMON_CNT_MAX) ? s_q.cnt[m] + 5'h01 : s_q.cnt[m];
				if (s_q.ctrl[m].method == ADCMON_METHOD_CUMUL) begin
					if (nxt >= target(s_q.ctrl[m].judge_count)) begin
						s_d.pulse[m] = 1'b1;
						s_d.cnt[m]   = '0;
					end else begin
						s_d.cnt[m] = nxt;
					end
				end else begin
					s_d.cnt[m]   = nxt;
					// Saturated counter keeps firing on each match
					s_d.pulse[m] = (nxt >= target(s_q.ctrl[m].judge_count));
				end
			end else if (fire[m] && s_q.ctrl[m].method == ADCMON_METHOD_SERIAL) begin
				s_d.cnt[m] = '0;
			end
			// Failing cumulative conversion falls through and holds
		end
		// Register writes
		if (bus.we) begin
			unique case (bus.addr)
				ADCMON_OFS_CTRL0: begin
					s_d.ctrl[0] = ctrl_unpack(bus.wdata);
					if (!s_d.ctrl[0].enable) begin
						s_d.cnt[0] = '0;
					end
				end
				ADCMON_OFS_CTRL1: begin
					s_d.ctrl[1] = ctrl_unpack(bus.wdata);
					if (!s_d.ctrl[1].enable) begin
						s_d.cnt[1] = '0;
					end
				end
				ADCMON_OFS_MASK: begin
					s_d.mask = bus.wdata[ADCMON_NUM_MON-1:0];
				end
				default: begin
				end
			endcase
		end
		// Sticky status, set wins over write-one-to-clear
		if (bus.we && bus.addr == ADCMON_OFS_STATUS) begin
			s_d.status = s_q.status & ~bus.wdata[ADCMON_NUM_MON-1:0];
		end
		s_d.status = s_d.status | s_d.pulse;
		// Read data for the following cycle
		if (bus.re) begin
			unique case (bus.addr)
				ADCMON_OFS_CTRL0:  s_d.rdata = ctrl_pack(s_q.ctrl[0]);
				ADCMON_OFS_CTRL1:  s_d.rdata = ctrl_pack(s_q.ctrl[1]);
				ADCMON_OFS_STATUS: s_d.rdata = {30'h0000_0000, s_q.status};
				ADCMON_OFS_MASK:   s_d.rdata = {30'h0000_0000, s_q.mask};
				default:           s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q.ctrl   <= {ADCMON_CTRL_RST, ADCMON_CTRL_RST};
			s_q.cnt    <= '0;
			s_q.status <= '0;
			s_q.mask   <= '0;
			s_q.pulse  <= '0;
			s_q.rdata  <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata     = s_q.rdata;
	assign monitor_irq_0 = s_q.pulse[0];
	assign monitor_irq_1 = s_q.pulse[1];
	assign irq           = |(s_q.status & s_q.mask);

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_irq_has_cause: assert property (monitor_irq_0 |-> $past(fire[0] && match[0]))
		else $error("monitor 0 pulse without matching conversion");
	a_serial_reach: assert property (fire[0] && match[0] && s_q.ctrl[0].method == ADCMON_METHOD_SERIAL &&
				     s_q.cnt[0] + 5'h01 == target(s_q.ctrl[0].judge_count) |=> monitor_irq_0)
		else $error("serial count reached without pulse");
	a_serial_repeat: assert property (fire[0] && match[0] && s_q.ctrl[0].method == ADCMON_METHOD_SERIAL &&
				      s_q.cnt[0] >= target(s_q.ctrl[0].judge_count) |=> monitor_irq_0)
		else $error("serial repeat pulse missing");
	a_serial_clear: assert property (fire[0] && !match[0] && s_q.ctrl[0].method == ADCMON_METHOD_SERIAL
				     |=> s_q.cnt[0] == '0)
		else $error("serial counter not cleared on mismatch");
	a_cumul_clear: assert property (monitor_irq_1 && $past(s_q.ctrl[1].method) == ADCMON_METHOD_CUMUL
				    |-> s_q.cnt[1] == '0 && $past(s_q.cnt[1]) + 5'h01 >= $past(target(s_q.ctrl[1].judge_count)))
		else $error("cumulative pulse at wrong count or counter kept");
	a_cumul_hold: assert property (fire[0] && !match[0] && s_q.ctrl[0].method == ADCMON_METHOD_CUMUL &&
				   !bus.we |=> $stable(s_q.cnt[0]))
		else $error("cumulative counter moved on mismatch");
	a_dir_smaller: assert property (fire[1] && s_q.ctrl[1].direction == ADCMON_DIR_SMALLER &&
				    conv.result >= cmp_val[1] && s_q.ctrl[1].method == ADCMON_METHOD_SERIAL
				    |=> s_q.cnt[1] == '0 && !monitor_irq_1)
		else $error("smaller direction matched a non-smaller result");
	a_bad_channel: assert property (s_q.ctrl[1].channel_sel >= 4'hC |-> !fire[1])
		else $error("unselectable channel produced an event");
	a_mode_gate: assert property (!repeat_mode |=> !monitor_irq_0 && !monitor_irq_1)
		else $error("pulse outside repeat modes");
	a_every_match: assert property (fire[1] && match[1] && s_q.ctrl[1].judge_count == 4'h0 |=> monitor_irq_1)
		else $error("count code zero did not fire on each match");
	a_disable_clear: assert property (!s_q.ctrl[0].enable |=> s_q.cnt[0] == '0)
		else $error("disabled monitor kept a count");
	a_status_sticky: assert property (monitor_irq_1 |-> s_q.status[1] ##1 s_q.status[1] || $past(bus.we))
		else $error("status bit of monitor 1 not set by its pulse");

	// Mirrors for the other monitor, then further checks, a_cumul0_keep, a_count_top and a_status_set0 on monitor 0 only
	a_irq1_has_cause: assert property (monitor_irq_1 |->
			$past(fire[1] && match[1]))
		else $error("monitor 1 pulse without matching conversion");
	a_serial1_reach: assert property (fire[1] && match[1] && s_q.ctrl[1].method == ADCMON_METHOD_SERIAL &&
			s_q.cnt[1] + 5'h01 == target(s_q.ctrl[1].judge_count) |=> monitor_irq_1)
		else $error("serial count reached without pulse on monitor 1");
	a_serial1_repeat: assert property (fire[1] && match[1] && s_q.ctrl[1].method == ADCMON_METHOD_SERIAL &&
			s_q.cnt[1] >= target(s_q.ctrl[1].judge_count) |=> monitor_irq_1)
		else $error("serial repeat pulse missing on monitor 1");
	a_serial1_clear: assert property (fire[1] && !match[1] && s_q.ctrl[1].method == ADCMON_METHOD_SERIAL
			|=> s_q.cnt[1] == '0)
		else $error("serial counter of monitor 1 not cleared on mismatch");
	a_cumul0_clear: assert property (monitor_irq_0 && $past(s_q.ctrl[0].method) == ADCMON_METHOD_CUMUL |->
			s_q.cnt[0] == '0 && $past(s_q.cnt[0]) + 5'h01 >= $past(target(s_q.ctrl[0].judge_count)))
		else $error("cumulative pulse of monitor 0 at wrong count");
	a_cumul0_below: assert property (fire[0] && match[0] && s_q.ctrl[0].method == ADCMON_METHOD_CUMUL && !bus.we &&
			s_q.cnt[0] + 5'h01 < target(s_q.ctrl[0].judge_count) |=> !monitor_irq_0 && s_q.cnt[0] == $past(s_q.cnt[0]) + 5'h01)
		else $error("cumulative count of monitor 0 did not step");
	a_cumul1_below: assert property (fire[1] && match[1] && s_q.ctrl[1].method == ADCMON_METHOD_CUMUL && !bus.we &&
			s_q.cnt[1] + 5'h01 < target(s_q.ctrl[1].judge_count) |=> !monitor_irq_1 && s_q.cnt[1] == $past(s_q.cnt[1]) + 5'h01)
		else $error("cumulative count of monitor 1 did not step");
	a_cumul1_hold: assert property (fire[1] && !match[1] && s_q.ctrl[1].method == ADCMON_METHOD_CUMUL &&
			!bus.we |=> $stable(s_q.cnt[1]))
		else $error("cumulative counter of monitor 1 moved on mismatch");
	a_cumul0_keep: assert property (fire[0] && !match[0] && s_q.ctrl[0].method == ADCMON_METHOD_CUMUL
			|=> !monitor_irq_0)
		else $error("cumulative mismatch on monitor 0 fired");
	a_dir0_smaller: assert property (fire[0] && s_q.ctrl[0].direction == ADCMON_DIR_SMALLER && conv.result >= cmp_val[0] &&
			s_q.ctrl[0].method == ADCMON_METHOD_SERIAL |=> s_q.cnt[0] == '0 && !monitor_irq_0)
		else $error("smaller direction matched a non-smaller result on monitor 0");
	a_dir0_bigger: assert property (fire[0] && s_q.ctrl[0].direction == ADCMON_DIR_BIGGER && conv.result <= cmp_val[0] &&
			s_q.ctrl[0].method == ADCMON_METHOD_SERIAL |=> s_q.cnt[0] == '0 && !monitor_irq_0)
		else $error("bigger direction matched a non-bigger result on monitor 0");
	a_dir1_bigger: assert property (fire[1] && s_q.ctrl[1].direction == ADCMON_DIR_BIGGER && conv.result <= cmp_val[1] &&
			s_q.ctrl[1].method == ADCMON_METHOD_SERIAL |=> s_q.cnt[1] == '0 && !monitor_irq_1)
		else $error("bigger direction matched a non-bigger result on monitor 1");
	a_other_chan0: assert property (conv.channel != s_q.ctrl[0].channel_sel |->
			!fire[0])
		else $error("monitor 0 took a conversion of another channel");
	a_other_chan1: assert property (conv.channel != s_q.ctrl[1].channel_sel |->
			!fire[1])
		else $error("monitor 1 took a conversion of another channel");
	a_bad_channel0: assert property ({1'b0, s_q.ctrl[0].channel_sel} >= 5'(NUM_CH) |->
			!fire[0])
		else $error("unselectable channel produced an event on monitor 0");
	a_mode_fire: assert property (!repeat_mode |->
			fire == '0)
		else $error("conversion taken outside repeat modes");
	a_every_match0: assert property (fire[0] && match[0] && s_q.ctrl[0].judge_count == 4'h0
			|=> monitor_irq_0)
		else $error("count code zero did not fire on each match of monitor 0");
	a_count_top: assert property (fire[0] && match[0] && s_q.ctrl[0].method == ADCMON_METHOD_SERIAL &&
			s_q.ctrl[0].judge_count == 4'hF && s_q.cnt[0] < 5'h0F |=> !monitor_irq_0)
		else $error("count code fifteen fired early");
	a_serial0_step: assert property (fire[0] && match[0] && s_q.ctrl[0].method == ADCMON_METHOD_SERIAL && !bus.we &&
			s_q.cnt[0] < ADCMON_CNT_MAX |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 5'h01)
		else $error("serial count of monitor 0 did not step");
	a_serial1_step: assert property (fire[1] && match[1] && s_q.ctrl[1].method == ADCMON_METHOD_SERIAL && !bus.we &&
			s_q.cnt[1] < ADCMON_CNT_MAX |=> s_q.cnt[1] == $past(s_q.cnt[1]) + 5'h01)
		else $error("serial count of monitor 1 did not step");
	a_disable_clear1: assert property (!s_q.ctrl[1].enable |=>
			s_q.cnt[1] == '0)
		else $error("disabled monitor 1 kept a count");
	a_enable_gate: assert property (!s_q.ctrl[0].enable && !s_q.ctrl[1].enable |->
			fire == '0)
		else $error("disabled monitor took a conversion");
	a_status_set0: assert property (monitor_irq_0 |->
			s_q.status[0])
		else $error("status bit of monitor 0 not set by its pulse");
	a_irq_quiet: assert property (s_q.status == '0 |->
			!irq)
		else $error("interrupt line high with no status bit");

	c_serial_fire: cover property (s_q.ctrl[0].method == ADCMON_METHOD_SERIAL && monitor_irq_0 ##1 monitor_irq_0);
	c_cumul_fire:  cover property (s_q.ctrl[1].method == ADCMON_METHOD_CUMUL && monitor_irq_1);
	c_both_fire:   cover property (monitor_irq_0 && monitor_irq_1);
	c_irq_line:    cover property (irq ##1 !irq);
	c_cumul0_fire: cover property (s_q.ctrl[0].method == ADCMON_METHOD_CUMUL && monitor_irq_0);

endmodule
